// ==== ofsc_pkg.sv ====
package ofsc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 12;
  localparam logic START_BIT_VALUE = 1'b0;
  localparam logic FREEZE_VALUE = 1'b0;
  localparam logic [FRAME_BITS-1:0] PATTERN_RESET = 12'hfff;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_WIDTH = 4;
  localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] COUNT_ADDR = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] CONTROL_ADDR = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STATUS_BUSY_BIT = 16;
  localparam int CONTROL_COUNT_EN_BIT = 0;
  localparam int CONTROL_COUNT_CLR_BIT = 1;
  localparam int COUNT_WIDTH = 16;
  localparam logic CONTROL_COUNT_EN_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SHIFT = 2'b01,
    RX_APPLY = 2'b10
  } ofsc_rx_state_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_WIDTH-1:0] address;
    logic [31:0] writedata;
  } ofsc_avs_req_type;

endpackage

// ==== ofsc_sync3.sv ====
`timescale 1ns/1ps
module ofsc_sync3 import ofsc_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Level crossing
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] out_ff;
  wire [WIDTH-1:0] agree = ~(stage2_ff ^ stage3_ff);
  wire [WIDTH-1:0] nxt_out = (agree & stage3_ff) | (~agree & out_ff);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
      out_ff <= RESET_VAL;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      out_ff <= nxt_out;
    end
  end

  assign syncOut = out_ff;

endmodule // ofsc_sync3

// ==== ofsc_gate_cell.sv ====
`timescale 1ns/1ps
module ofsc_gate_cell import ofsc_pkg::*; (
  // Source clock and reset
  input wire logic srcClock,
  input wire logic resetn,
  // Enable from the link domain
  input wire logic runEnable,
  // Gated clock
  output logic gatedClock
);

  logic runSynced;
  logic gateOpen_ff;

  ofsc_sync3 #(.WIDTH(1), .RESET_VAL(1'b1)) uRunSync (
    .clock(srcClock),
    .resetn(resetn),
    .asyncIn(runEnable),
    .syncOut(runSynced)
  );

  // ----------------------------------------------------------------
  // Gate moves only while the source sits low
  // ----------------------------------------------------------------
  always_ff @(negedge srcClock) begin
    if (!resetn) begin
      gateOpen_ff <= 1'b1;
    end else begin
      gateOpen_ff <= runSynced;
    end
  end

  assign gatedClock = srcClock & gateOpen_ff;

  chk_freeze_falls: assert property (@(posedge srcClock) disable iff (!resetn)
    (runSynced == FREEZE_VALUE) |-> (gateOpen_ff == 1'b0))
    else $error("freeze did not close the gate by the next low phase");

  chk_release_rises: assert property (@(posedge srcClock) disable iff (!resetn)
    (runSynced != FREEZE_VALUE) |-> (gateOpen_ff == 1'b1))
    else $error("release did not open the gate by the next low phase");

endmodule // ofsc_gate_cell

// ==== ofsc_top.sv ====
`timescale 1ns/1ps
// Contract
// - Twelve outputs freezable; bank C first, feedback run
// - Twelve-bit shift register, one bit per output
// - Control only via serial data and clock
// - Data sampled on serial clock rising edge
// - Zero freezes output, one releases it
// - Freeze state unchanged while frame shifts in
// - Pattern applied at edge after twelfth bit
// - Bit after frame: zero starts, else idle
// - Freeze lets output fall at natural edge
// - Release lets output rise at natural edge
module ofsc_top import ofsc_pkg::*; #(
  parameter int FREEZE_COUNT = FRAME_BITS,
  parameter bit MSB_FIRST = 1'b1
) (
  // System clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Avalon-MM slave
  input wire ofsc_avs_req_type avsReq,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Freeze serial link
  input wire logic freeze_serial_clock,
  input wire logic freeze_serial_data,
  // Clock sources
  input wire logic [FREEZE_COUNT-1:0] rawClocks,
  input wire logic bank_c_first_output_in,
  input wire logic feedback_output_in,
  // Clock outputs
  output logic [FREEZE_COUNT-1:0] gatedClocks,
  output logic bank_c_first_output,
  output logic feedback_output
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int CNT_W = 4;

  generate
    if (FREEZE_COUNT != FRAME_BITS) begin : gBadCount
      $error("FREEZE_COUNT must match the frame length");
    end
    if (FREEZE_COUNT < 2 || FREEZE_COUNT >= (1 << CNT_W)) begin : gBadWidth
      $error("FREEZE_COUNT out of counter range");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FREEZE_COUNT - 1);
  localparam logic [CNT_W-1:0] FIRST_BIT = '0;
  localparam logic [CNT_W-1:0] ONE_BIT = CNT_W'(1);

  // ----------------------------------------------------------------
  // Free-running outputs
  // ----------------------------------------------------------------
  assign bank_c_first_output = bank_c_first_output_in;
  assign feedback_output = feedback_output_in;

  // ----------------------------------------------------------------
  // Link-domain reset
  // ----------------------------------------------------------------
  logic linkRst1_ff;
  logic linkRst2_ff;
  logic linkRst3_ff;
  logic linkRstn_ff;
  wire linkRstAgree = (linkRst2_ff == linkRst3_ff);
  wire nxt_linkRstn = linkRstAgree ? linkRst3_ff : linkRstn_ff;

  always_ff @(posedge freeze_serial_clock) begin
    linkRst1_ff <= resetn;
    linkRst2_ff <= linkRst1_ff;
    linkRst3_ff <= linkRst2_ff;
    linkRstn_ff <= nxt_linkRstn;
  end

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  ofsc_rx_state_type rxState_ff;
  ofsc_rx_state_type nxt_rxState;
  logic [CNT_W-1:0] bitCount_ff;
  logic [CNT_W-1:0] nxt_bitCount;
  logic [FREEZE_COUNT-1:0] shiftReg_ff;
  logic [FREEZE_COUNT-1:0] nxt_shiftReg;
  logic [FREEZE_COUNT-1:0] pattern_ff;
  logic [FREEZE_COUNT-1:0] nxt_pattern;
  logic applyToggle_ff;
  logic nxt_applyToggle;

  wire serialIsStart = (freeze_serial_data == START_BIT_VALUE);
  wire lastBit = (bitCount_ff == LAST_BIT);
  wire [FREEZE_COUNT-1:0] shiftedMsb = {shiftReg_ff[FREEZE_COUNT-2:0], freeze_serial_data};
  wire [FREEZE_COUNT-1:0] shiftedLsb = {freeze_serial_data, shiftReg_ff[FREEZE_COUNT-1:1]};
  wire [FREEZE_COUNT-1:0] shiftedReg = MSB_FIRST ? shiftedMsb : shiftedLsb;
  wire newestBit = MSB_FIRST ? shiftReg_ff[0] : shiftReg_ff[FREEZE_COUNT-1];
  wire linkBusy = (rxState_ff != RX_IDLE);

  always_comb begin
    nxt_rxState = rxState_ff;
    nxt_bitCount = bitCount_ff;
    nxt_shiftReg = shiftReg_ff;
    nxt_pattern = pattern_ff;
    nxt_applyToggle = applyToggle_ff;
    case (rxState_ff)
      RX_IDLE: begin
        if (serialIsStart) begin
          nxt_rxState = RX_SHIFT;
          nxt_bitCount = FIRST_BIT;
        end
      end
      RX_SHIFT: begin
        nxt_shiftReg = shiftedReg;
        nxt_bitCount = bitCount_ff + ONE_BIT;
        if (lastBit) begin
          nxt_rxState = RX_APPLY;
        end
      end
      RX_APPLY: begin
        nxt_pattern = shiftReg_ff;
        nxt_applyToggle = ~applyToggle_ff;
        nxt_bitCount = FIRST_BIT;
        if (serialIsStart) begin
          nxt_rxState = RX_SHIFT;
        end else begin
          nxt_rxState = RX_IDLE;
        end
      end
      default: begin
        nxt_rxState = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge freeze_serial_clock) begin
    if (!linkRstn_ff) begin
      rxState_ff <= RX_IDLE;
      bitCount_ff <= FIRST_BIT;
      shiftReg_ff <= PATTERN_RESET;
      pattern_ff <= PATTERN_RESET;
      applyToggle_ff <= 1'b0;
    end else begin
      rxState_ff <= nxt_rxState;
      bitCount_ff <= nxt_bitCount;
      shiftReg_ff <= nxt_shiftReg;
      pattern_ff <= nxt_pattern;
      applyToggle_ff <= nxt_applyToggle;
    end
  end

  // ----------------------------------------------------------------
  // Output gates
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < FREEZE_COUNT; i++) begin : gGate
      ofsc_gate_cell uGate (
        .srcClock(rawClocks[i]),
        .resetn(resetn),
        .runEnable(pattern_ff[i]),
        .gatedClock(gatedClocks[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Crossing to the system domain
  // ----------------------------------------------------------------
  logic applyToggleSync;
  logic busySync;
  logic toggleSeen_ff;
  logic [FREEZE_COUNT-1:0] statusPattern_ff;
  logic [FREEZE_COUNT-1:0] nxt_statusPattern;

  ofsc_sync3 #(.WIDTH(1), .RESET_VAL(1'b0)) uToggleSync (
    .clock(clock),
    .resetn(resetn),
    .asyncIn(applyToggle_ff),
    .syncOut(applyToggleSync)
  );

  ofsc_sync3 #(.WIDTH(1), .RESET_VAL(1'b0)) uBusySync (
    .clock(clock),
    .resetn(resetn),
    .asyncIn(linkBusy),
    .syncOut(busySync)
  );

  wire applyEvent = applyToggleSync ^ toggleSeen_ff;
  // Pattern is held for a whole frame after each toggle
  assign nxt_statusPattern = applyEvent ? pattern_ff : statusPattern_ff;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      toggleSeen_ff <= 1'b0;
      statusPattern_ff <= PATTERN_RESET;
    end else begin
      toggleSeen_ff <= applyToggleSync;
      statusPattern_ff <= nxt_statusPattern;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [31:0] readData_ff;
  logic countEnable_ff;
  logic [COUNT_WIDTH-1:0] frameCount_ff;

  wire reqActive = avsReq.read | avsReq.write;
  wire nxt_ack = reqActive & ~ack_ff;
  wire hitStatus = (avsReq.address == STATUS_ADDR);
  wire hitCount = (avsReq.address == COUNT_ADDR);
  wire hitControl = (avsReq.address == CONTROL_ADDR);
  wire writeCommit = avsReq.write & ack_ff;
  wire controlWrite = writeCommit & hitControl;
  wire countClear = controlWrite & avsReq.writedata[CONTROL_COUNT_CLR_BIT];
  wire nxt_countEnable = controlWrite ? avsReq.writedata[CONTROL_COUNT_EN_BIT] : countEnable_ff;

  logic [31:0] statusWord;
  logic [31:0] countWord;
  logic [31:0] controlWord;
  logic [31:0] readMux;

  always_comb begin
    statusWord = '0;
    statusWord[FREEZE_COUNT-1:0] = statusPattern_ff;
    statusWord[STATUS_BUSY_BIT] = busySync;
    countWord = '0;
    countWord[COUNT_WIDTH-1:0] = frameCount_ff;
    controlWord = '0;
    controlWord[CONTROL_COUNT_EN_BIT] = countEnable_ff;
  end

  assign readMux = hitStatus ? statusWord :
                   hitCount ? countWord :
                   hitControl ? controlWord : 32'h0000_0000;

  wire [31:0] nxt_readData = (avsReq.read & ~ack_ff) ? readMux : readData_ff;

  // A clear acts first; an applied frame in the same cycle then counts from zero
  logic [COUNT_WIDTH-1:0] clearedCount;
  logic [COUNT_WIDTH-1:0] nxt_frameCount;
  assign clearedCount = countClear ? '0 : frameCount_ff;
  assign nxt_frameCount = (applyEvent & countEnable_ff) ? clearedCount + COUNT_WIDTH'(1) : clearedCount;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
      readData_ff <= 32'h0000_0000;
      countEnable_ff <= CONTROL_COUNT_EN_RESET;
      frameCount_ff <= '0;
    end else begin
      ack_ff <= nxt_ack;
      readData_ff <= nxt_readData;
      countEnable_ff <= nxt_countEnable;
      frameCount_ff <= nxt_frameCount;
    end
  end

  assign avsWaitRequest = reqActive & ~ack_ff;
  assign avsReadData = readData_ff;

  // ----------------------------------------------------------------
  // Checks in the link domain
  // ----------------------------------------------------------------
  sequence sStartSeen;
    (rxState_ff == RX_IDLE) && serialIsStart;
  endsequence

  sequence sTwelfthBit;
    (rxState_ff == RX_SHIFT) && lastBit;
  endsequence

  chk_frame_length: assert property (@(posedge freeze_serial_clock) disable iff (!linkRstn_ff)
    sStartSeen |=> (rxState_ff == RX_SHIFT) ##11 ((rxState_ff == RX_SHIFT) && lastBit) ##1 (rxState_ff == RX_APPLY))
    else $error("frame did not take twelve data bits");

  chk_sample_rise: assert property (@(posedge freeze_serial_clock) disable iff (!linkRstn_ff)
    (rxState_ff == RX_SHIFT) |=> (newestBit == $past(freeze_serial_data)))
    else $error("shift register missed the sampled data bit");

  chk_hold_midframe: assert property (@(posedge freeze_serial_clock) disable iff (!linkRstn_ff)
    (rxState_ff != RX_APPLY) |=> $stable(pattern_ff))
    else $error("freeze pattern changed before the frame completed");

  chk_apply_next: assert property (@(posedge freeze_serial_clock) disable iff (!linkRstn_ff)
    sTwelfthBit |=> (rxState_ff == RX_APPLY) ##1 (pattern_ff == $past(shiftReg_ff)))
    else $error("pattern not applied at the edge after the twelfth bit");

  chk_back_start: assert property (@(posedge freeze_serial_clock) disable iff (!linkRstn_ff)
    ((rxState_ff == RX_APPLY) && serialIsStart) |=> ((rxState_ff == RX_SHIFT) && (bitCount_ff == FIRST_BIT)))
    else $error("zero after a frame did not start the next frame");

  chk_idle_wait: assert property (@(posedge freeze_serial_clock) disable iff (!linkRstn_ff)
    (((rxState_ff == RX_APPLY) || (rxState_ff == RX_IDLE)) && !serialIsStart) |=> (rxState_ff == RX_IDLE))
    else $error("receiver left idle without a start bit");

  // ----------------------------------------------------------------
  // Checks in the system domain
  // ----------------------------------------------------------------
  chk_free_outputs: assert property (@(posedge clock) disable iff (!resetn)
    (bank_c_first_output == bank_c_first_output_in) && (feedback_output == feedback_output_in))
    else $error("a non-freezable output was altered");

  chk_bus_answer: assert property (@(posedge clock) disable iff (!resetn)
    (reqActive && avsWaitRequest) |=> !avsWaitRequest)
    else $error("bus answer took more than one wait cycle");

  chk_status_update: assert property (@(posedge clock) disable iff (!resetn)
    applyEvent |=> (statusPattern_ff == $past(pattern_ff)))
    else $error("status did not capture the applied pattern");

endmodule // ofsc_top

// ==== ofsc_frz_host.sv ====
`timescale 1ns/1ps
module ofsc_frz_host import ofsc_pkg::*; (
  // Freeze serial link
  output logic serialClock,
  output logic serialData
);
  // ----------------------------------------
  // Link driver
  // ----------------------------------------
  // Clock stands still low; data released to pull-up level
  initial begin
    serialClock = 1'b0;
    serialData = 1'b1;
  end

  // One bit per link period, settled before the rising edge
  task automatic sendBit(input logic b);
    serialData = b;
    #24;
    serialClock = 1'b1;
    #24;
    serialClock = 1'b0;
  endtask

  // Ones while idle are ignored by the receiver
  task automatic idleBits(input int n);
    repeat (n) sendBit(1'b1);
  endtask

  // Start bit, then pattern from its top bit down
  task automatic sendFrame(input logic [FRAME_BITS-1:0] pat);
    sendBit(START_BIT_VALUE);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      sendBit(pat[i]);
    end
  endtask
endmodule // ofsc_frz_host

// ==== tb_output_freeze_serial_control.sv ====
`timescale 1ns/1ps
module tb_output_freeze_serial_control import ofsc_pkg::*;;
  logic clock;
  logic resetn;
  ofsc_avs_req_type avsReq;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic serialClock;
  logic serialData;
  logic [FRAME_BITS-1:0] rawClocks;
  logic bankCIn;
  logic fbIn;
  logic [FRAME_BITS-1:0] fixedPats[4] = '{12'h000, 12'h800, 12'h001, 12'hfff};
  logic [FRAME_BITS-1:0] gatedClocks;
  logic bankCOut;
  logic fbOut;
  logic [31:0] expQ[$];
  logic [FRAME_BITS-1:0] curPat = PATTERN_RESET;
  logic [FRAME_BITS-1:0] p;
  logic gateCheck = 1'b0;
  int countEn = 1;
  int expCount = 0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  ofsc_top #(.FREEZE_COUNT(FRAME_BITS), .MSB_FIRST(1'b1)) u_dut (
    .clock(clock), .resetn(resetn), .avsReq(avsReq), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .freeze_serial_clock(serialClock), .freeze_serial_data(serialData),
    .rawClocks(rawClocks), .bank_c_first_output_in(bankCIn), .feedback_output_in(fbIn),
    .gatedClocks(gatedClocks), .bank_c_first_output(bankCOut), .feedback_output(fbOut)
  );

  ofsc_frz_host u_host (.serialClock(serialClock), .serialData(serialData));

  // ----------------------------------------
  // Clocks and sources
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  for (genvar g = 0; g < FRAME_BITS; g++) begin : gRaw
    initial begin
      rawClocks[g] = 1'b0;
      forever #(7 + g) rawClocks[g] = ~rawClocks[g];
    end
    always @(posedge rawClocks[g]) begin
      if (gateCheck) begin
        #1;
        check("gatedHigh", {31'h0, gatedClocks[g]}, {31'h0, curPat[g]});
      end
    end
    always @(negedge rawClocks[g]) begin
      if (gateCheck) begin
        #1;
        check("gatedLow", {31'h0, gatedClocks[g]}, 32'h0);
      end
    end
  end

  always @(posedge clock) begin
    {bankCIn, fbIn} <= 2'($urandom);
  end

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(negedge clock) begin
    if (resetn) begin
      check("bankC", {31'h0, bankCOut}, {31'h0, bankCIn});
      check("feedback", {31'h0, fbOut}, {31'h0, fbIn});
    end
  end

  // Read data taken at the edge where waitrequest is low
  always @(posedge clock) begin
    if (avsReq.read && avsWaitRequest === 1'b0) begin
      if (expQ.size() == 0) check("readQueue", 32'h1, 32'h0);
      else check("readData", avsReadData, expQ.pop_front());
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------
  // Bus and frame tasks
  // ----------------------------------------
  task automatic busOp(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d);
    @(posedge clock);
    avsReq <= '{read: ~wr, write: wr, address: a, writedata: d};
    @(posedge clock);
    while (avsWaitRequest !== 1'b0) @(posedge clock);
    avsReq <= '0;
  endtask

  task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] e);
    expQ.push_back(e);
    busOp(1'b0, a, 32'h0);
  endtask

  task automatic frames(input logic [FRAME_BITS-1:0] a, input logic [FRAME_BITS-1:0] b, input bit two);
    gateCheck = 1'b0;
    u_host.sendFrame(a);
    if (two) u_host.sendFrame(b);
    u_host.sendBit(1'b1);
    curPat = two ? b : a;
    expCount += countEn * (two ? 2 : 1);
    repeat (20) @(posedge clock);
    gateCheck = 1'b1;
    rd(STATUS_ADDR, {20'h0, curPat});
    rd(COUNT_ADDR, 32'(expCount));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    avsReq = '0;
    void'($urandom(95));
    fork
      repeat (5) @(posedge clock);
      u_host.idleBits(6);
    join
    @(posedge clock);
    resetn <= 1'b1;
    u_host.idleBits(6);
    rd(STATUS_ADDR, {20'h0, PATTERN_RESET});
    rd(COUNT_ADDR, 32'h0);
    rd(CONTROL_ADDR, 32'h1);
    rd(4'hc, 32'h0);
    gateCheck = 1'b1;
    foreach (fixedPats[k]) begin
      frames(fixedPats[k], fixedPats[k], 1'b0);
    end
    repeat (3) begin
      u_host.idleBits(3);
      frames(12'($urandom), 12'($urandom), 1'b0);
    end
    frames(12'($urandom), 12'($urandom), 1'b1);
    // Half a frame must leave outputs as they are
    p = 12'($urandom);
    u_host.sendBit(1'b0);
    for (int i = 11; i >= 6; i--) u_host.sendBit(p[i]);
    repeat (20) @(posedge clock);
    rd(STATUS_ADDR, 32'h10000 | {20'h0, curPat});
    gateCheck = 1'b0;
    for (int i = 5; i >= 0; i--) u_host.sendBit(p[i]);
    u_host.sendBit(1'b1);
    curPat = p;
    expCount++;
    repeat (20) @(posedge clock);
    gateCheck = 1'b1;
    rd(STATUS_ADDR, {20'h0, p});
    busOp(1'b1, STATUS_ADDR, 32'h0);
    rd(STATUS_ADDR, {20'h0, curPat});
    busOp(1'b1, CONTROL_ADDR, 32'h0);
    rd(CONTROL_ADDR, 32'h0);
    countEn = 0;
    frames(12'($urandom), 12'h0, 1'b0);
    busOp(1'b1, CONTROL_ADDR, 32'h3);
    expCount = 0;
    rd(COUNT_ADDR, 32'h0);
    rd(CONTROL_ADDR, 32'h1);
    repeat (5) @(posedge clock);
    results();
  end
endmodule // tb_output_freeze_serial_control
